// ---- src/msc_pkg.sv ----
package msc_pkg;

  // ==========================================================
  // Sequence counter marks
  localparam logic [10:0] SEQ_IDLE       = 11'h000;
  localparam logic [10:0] SEQ_FIRST      = 11'h001;
  localparam logic [10:0] SEQ_LAST       = 11'h7ff;
  localparam logic [10:0] PRE_ZI_60      = 11'h06f;
  localparam logic [10:0] PRE_ZI_50      = 11'h001;
  localparam logic [10:0] INT_LEN_60     = 11'h221;
  localparam logic [10:0] INT_LEN_50     = 11'h28f;
  localparam logic [10:0] X8_LEN         = 11'h008;
  localparam logic [10:0] FINE_DEINT_MAX = 11'h03c;
  localparam logic [10:0] POST_ZI_LEN    = 11'h014;
  localparam logic [10:0] SLOT_LEN       = X8_LEN + FINE_DEINT_MAX;
  localparam logic [10:0] DEINT4_END     = SEQ_IDLE - POST_ZI_LEN;
  localparam logic [10:0] DEINT1_END     = DEINT4_END - SLOT_LEN - SLOT_LEN - SLOT_LEN;

  // ==========================================================
  // Results counter
  localparam int          RES_W      = 20;
  localparam logic [19:0] STEP_D1    = 20'h00200;
  localparam logic [19:0] STEP_D2    = 20'h00040;
  localparam logic [19:0] STEP_D3    = 20'h00008;
  localparam logic [19:0] STEP_D4    = 20'h00001;
  localparam logic [19:0] HARD_LIMIT = 20'h558e8;
  localparam logic [19:0] RES_RST    = 20'h00000;

  // ==========================================================
  // Register map
  localparam int         ADDR_W      = 8;
  localparam logic [7:0] REG_CMD     = 8'h00;
  localparam logic [7:0] REG_PORT    = 8'h04;
  localparam logic [7:0] REG_SEQ     = 8'h08;
  localparam int         CMD_START   = 7;
  localparam int         CMD_FREQ    = 6;
  localparam int         CMD_SEL_LSB = 0;
  localparam logic [1:0] SEL_LO      = 2'h0;
  localparam logic [1:0] SEL_HI      = 2'h1;
  localparam logic [1:0] SEL_STATUS  = 2'h2;
  localparam logic [1:0] SEL_RST     = 2'h0;
  localparam int         STS_INT     = 3;
  localparam int         STS_EOC     = 4;
  localparam int         STS_COLL    = 5;
  localparam int         STS_SIGN    = 6;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // Conversion phases
  typedef enum logic [6:0] {
    ST_IDLE  = 7'h01,
    ST_PRE   = 7'h02,
    ST_INT   = 7'h04,
    ST_DEINT = 7'h08,
    ST_REST  = 7'h10,
    ST_X8    = 7'h20,
    ST_POST  = 7'h40
  } msc_state_t;

endpackage

// ---- src/msc_sync2.sv ----
`timescale 1ns/100ps
module msc_sync2 (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic async_in,
  output logic      sync_out
);
  typedef struct packed {
    logic s1;
    logic s2;
  } msc_sync_t;

  msc_sync_t r;
  msc_sync_t next_r;

  always_comb begin
    next_r.s1 = async_in;
    next_r.s2 = r.s1;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign sync_out = r.s2;
endmodule // msc_sync2

// ---- src/msc_results_acc.sv ----
`timescale 1ns/100ps
module msc_results_acc (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        clear,
  input  wire logic        count_en,
  input  wire logic        count_up,
  input  wire logic [1:0]  stage,
  output logic      [19:0] value
);
  typedef struct packed {
    logic [19:0] acc;
  } msc_acc_t;

  msc_acc_t r;
  msc_acc_t next_r;

  // Weighted step, clamped at the hard limit
  function automatic logic [19:0] sat_step(input logic [19:0] acc, input logic [19:0] step,
                                            input logic up);
    logic signed [20:0] sum;
    logic signed [20:0] lim;
    sum = up ? ($signed({acc[19], acc}) + $signed({1'b0, step}))
             : ($signed({acc[19], acc}) - $signed({1'b0, step}));
    lim = $signed({1'b0, msc_pkg::HARD_LIMIT});
    if (sum > lim) begin
      sat_step = msc_pkg::HARD_LIMIT;
    end else if (sum < -lim) begin
      sat_step = 20'h00000 - msc_pkg::HARD_LIMIT;
    end else begin
      sat_step = sum[19:0];
    end
  endfunction

  always_comb begin
    logic [19:0] step;
    step   = msc_pkg::STEP_D4;
    next_r = r;
    case (stage)
      2'h0: step = msc_pkg::STEP_D1;
      2'h1: step = msc_pkg::STEP_D2;
      2'h2: step = msc_pkg::STEP_D3;
      default: step = msc_pkg::STEP_D4;
    endcase
    // R26 cleared on start
    if (clear) begin
      next_r.acc = msc_pkg::RES_RST;
    // R5 up/down counting
    end else if (count_en) begin
      // R8 saturate at limit
      next_r.acc = sat_step(r.acc, step, count_up);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      r.acc <= 20'h00000;
    end else begin
      r <= next_r;
    end
  end

  assign value = r.acc;
endmodule // msc_results_acc

// ---- src/msc_sequencer.sv ----
// The AXI4-Lite register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
// How it works
// R1 - A status read clears the collision flag to zero.
// R2 - No collision when result reads complete before the next latch.
// R3 - Host checks collision before and after reading both result registers.
// R4 - Sequence counter fixes integrate bounds; deintegrate ends early on zero crossing.
// R5 - Results counter counts up or down only while deintegrating.
// R6 - Counter steps are 512, 64, 8 and 1 in the four deintegrations.
// R7 - Counter value is copied to the results register at conversion end.
// R8 - Result saturates at plus or minus 350,440 counts.
// R9 - Host applies its own soft overrange below 279,040 raw counts.
// R10 - Integration lasts 545 counts at 60Hz and 655 at 50Hz.
// R11 - Integrator sign picks first deintegration polarity; rest follows the crossing.
// R12 - Rest runs from crossing until the phase's maximum count.
// R13 - Polarity is resampled before each later deintegration.
// R14 - A detected crossing stops deintegration at the next clock edge.
// R15 - Three times-eight residue phases give four deintegrations in total.
// R16 - Device stays in zero-integrate while idle until a start.
// R17 - Start adds 111 zero-integrate clocks at 60Hz, one at 50Hz.
// R18 - Twenty zero-integrate clocks close every conversion.
// R19 - Port read returns the register selected by the preceding command write.
// R20 - Host discards the first result after a gap over 2 seconds.
// R21 - Host uses 50Hz mode above 16 conversions per second.
// R22 - Conversion spans 2048 counts; done rises at 0000, falls at 0001.
// R23 - Line frequency bit 0 selects 60Hz timing, 1 selects 50Hz.
// R24 - Start bit begins one conversion; device halts at its end.
// R25 - Integrate flag is high exactly during the integrate phase.
// R26 - Results counter clears when a conversion starts.
module msc_sequencer (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        comp_in,
  output logic             zero_integrate_phase,
  output logic             integrate_phase,
  output logic             deint_phase,
  output logic             deint_ref_negative,
  output logic             rest_phase,
  output logic             residue_gain_phase,
  output logic             eoc,
  output logic             int_active
);

  // ==========================================================
  // State
  typedef struct packed {
    msc_pkg::msc_state_t st;
    logic [10:0]         seq;
    logic [1:0]          stage;
    logic                pol;
    logic                conv50;
    logic                line_freq_select;
    logic [1:0]          sel;
    logic                start_pend;
    logic [19:0]         result;
    logic                coll;
    logic                rd_lo;
    logic                rd_hi;
    logic                aw_held;
    logic [7:0]          aw_addr;
    logic                w_held;
    logic [31:0]         w_data;
    logic [3:0]          w_strb;
    logic                bvalid;
    logic [1:0]          bresp;
    logic                rvalid;
    logic [31:0]         rdata;
    logic [1:0]          rresp;
  } msc_regs_t;

  msc_regs_t   r;
  msc_regs_t   next_r;
  logic        comp_s;
  logic [19:0] acc_value;
  logic        acc_clear;
  logic        acc_en;
  logic        acc_up;
  logic        wr_fire;
  logic        rd_fire;

  // ==========================================================
  // Helpers
  function automatic logic [10:0] pre_len(input logic f50);
    pre_len = f50 ? msc_pkg::PRE_ZI_50 : msc_pkg::PRE_ZI_60;
  endfunction

  function automatic logic [10:0] int_last(input logic f50);
    // R10 integrate length
    int_last = pre_len(f50) + (f50 ? msc_pkg::INT_LEN_50 : msc_pkg::INT_LEN_60);
  endfunction

  function automatic logic [10:0] deint_end(input logic [1:0] stg);
    deint_end = msc_pkg::DEINT1_END + 11'(msc_pkg::SLOT_LEN * {9'h000, stg});
  endfunction

  function automatic logic [7:0] status_byte(input msc_regs_t q);
    status_byte                    = 8'h00;
    status_byte[2:0]               = q.result[2:0];
    status_byte[msc_pkg::STS_INT]  = (q.st == msc_pkg::ST_INT);
    status_byte[msc_pkg::STS_EOC]  = (q.st == msc_pkg::ST_IDLE);
    status_byte[msc_pkg::STS_COLL] = q.coll;
    status_byte[msc_pkg::STS_SIGN] = q.result[19];
  endfunction

  // ==========================================================
  // Comparator and results counter
  msc_sync2 u_comp_sync (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .async_in (comp_in),
    .sync_out (comp_s)
  );

  msc_results_acc u_acc (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .clear    (acc_clear),
    .count_en (acc_en),
    .count_up (acc_up),
    .stage    (r.stage),
    .value    (acc_value)
  );

  // ==========================================================
  // Next state
  always_comb begin
    next_r    = r;
    acc_clear = 1'b0;
    acc_en    = 1'b0;
    acc_up    = r.pol ^ r.stage[0];
    wr_fire   = r.aw_held && r.w_held && !r.bvalid;
    rd_fire   = s_axi_arvalid && !r.rvalid;

    // Bus channel capture and release
    if (s_axi_awvalid && !r.aw_held) begin
      next_r.aw_held = 1'b1;
      next_r.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !r.w_held) begin
      next_r.w_held = 1'b1;
      next_r.w_data = s_axi_wdata;
      next_r.w_strb = s_axi_wstrb;
    end
    if (r.bvalid && s_axi_bready) begin
      next_r.bvalid = 1'b0;
    end
    if (r.rvalid && s_axi_rready) begin
      next_r.rvalid = 1'b0;
    end

    // Register reads
    if (rd_fire) begin
      next_r.rvalid = 1'b1;
      next_r.rresp  = msc_pkg::RESP_OKAY;
      next_r.rdata  = 32'h00000000;
      if (s_axi_araddr == msc_pkg::REG_CMD) begin
        next_r.rdata[msc_pkg::CMD_START] = r.start_pend;
        next_r.rdata[msc_pkg::CMD_FREQ]  = r.line_freq_select;
        next_r.rdata[msc_pkg::CMD_SEL_LSB +: 2] = r.sel;
      end else if (s_axi_araddr == msc_pkg::REG_PORT) begin
        // R19 selected output register
        case (r.sel)
          msc_pkg::SEL_LO: begin
            next_r.rdata[7:0] = r.result[10:3];
            // R2 read cycle tracking
            next_r.rd_lo      = !r.rd_hi;
            next_r.rd_hi      = 1'b0;
          end
          msc_pkg::SEL_HI: begin
            next_r.rdata[7:0] = r.result[18:11];
            next_r.rd_hi      = !r.rd_lo;
            next_r.rd_lo      = 1'b0;
          end
          msc_pkg::SEL_STATUS: begin
            next_r.rdata[7:0] = status_byte(r);
            // R1 clear on status read
            next_r.coll       = 1'b0;
            next_r.rd_lo      = 1'b0;
            next_r.rd_hi      = 1'b0;
          end
          default: begin
            next_r.rdata[7:0] = 8'h00;
          end
        endcase
      end else if (s_axi_araddr == msc_pkg::REG_SEQ) begin
        next_r.rdata[10:0]  = r.seq;
        next_r.rdata[18:12] = r.st;
        next_r.rdata[21:20] = r.stage;
        next_r.rdata[24]    = r.pol;
      end else begin
        next_r.rresp = msc_pkg::RESP_SLVERR;
      end
    end

    // Conversion sequencer
    if (r.st != msc_pkg::ST_IDLE) begin
      // R4 binary sequence counter
      next_r.seq = r.seq + 11'h001;
    end
    case (r.st)
      msc_pkg::ST_IDLE: begin
        // R16 hold in zero-integrate
        // R24 start one conversion
        if (r.start_pend) begin
          next_r.start_pend = 1'b0;
          // R22 done falls at 0001
          next_r.seq        = msc_pkg::SEQ_FIRST;
          next_r.st         = msc_pkg::ST_PRE;
          next_r.conv50     = r.line_freq_select;
          next_r.stage      = 2'h0;
          // R26 clear counter
          acc_clear         = 1'b1;
        end
      end
      msc_pkg::ST_PRE: begin
        // R17 extra zero-integrate
        if (r.seq == pre_len(r.conv50)) begin
          next_r.st = msc_pkg::ST_INT;
        end
      end
      msc_pkg::ST_INT: begin
        // R4 fixed integrate end
        if (r.seq == int_last(r.conv50)) begin
          next_r.st    = msc_pkg::ST_DEINT;
          // R11 first polarity
          next_r.pol   = comp_s;
          next_r.stage = 2'h0;
        end
      end
      msc_pkg::ST_DEINT: begin
        // R5 count while deintegrating
        // R6 stage weighted step
        acc_en = 1'b1;
        if (r.seq == deint_end(r.stage) - 11'h001) begin
          next_r.st = (r.stage == 2'h3) ? msc_pkg::ST_POST : msc_pkg::ST_X8;
        // R14 stop next edge
        end else if (comp_s != r.pol) begin
          // R12 rest from crossing
          next_r.st = msc_pkg::ST_REST;
        end
      end
      msc_pkg::ST_REST: begin
        // R12 rest to maximum
        if (r.seq == deint_end(r.stage) - 11'h001) begin
          next_r.st = (r.stage == 2'h3) ? msc_pkg::ST_POST : msc_pkg::ST_X8;
        end
      end
      msc_pkg::ST_X8: begin
        // R15 residue gain then deintegrate
        if (r.seq == deint_end(r.stage) + msc_pkg::X8_LEN - 11'h001) begin
          next_r.st    = msc_pkg::ST_DEINT;
          next_r.stage = r.stage + 2'h1;
          // R13 resample polarity
          next_r.pol   = comp_s;
        end
      end
      msc_pkg::ST_POST: begin
        // R18 closing zero-integrate
        // R22 2048 count wrap
        if (r.seq == msc_pkg::SEQ_LAST) begin
          next_r.st     = msc_pkg::ST_IDLE;
          // R7 latch result
          next_r.result = acc_value;
          // R2 collision only mid-read
          if (r.rd_lo || r.rd_hi) begin
            next_r.coll = 1'b1;
          end
        end
      end
      default: begin
        next_r.st  = msc_pkg::ST_IDLE;
        next_r.seq = msc_pkg::SEQ_IDLE;
      end
    endcase

    // Register writes
    if (wr_fire) begin
      next_r.aw_held = 1'b0;
      next_r.w_held  = 1'b0;
      next_r.bvalid  = 1'b1;
      next_r.bresp   = msc_pkg::RESP_OKAY;
      if (r.aw_addr == msc_pkg::REG_CMD) begin
        if (r.w_strb[0]) begin
          // R19 select next read
          next_r.sel = r.w_data[msc_pkg::CMD_SEL_LSB +: 2];
          // R23 line frequency
          next_r.line_freq_select = r.w_data[msc_pkg::CMD_FREQ];
          if (r.w_data[msc_pkg::CMD_START]) begin
            next_r.start_pend = 1'b1;
          end
        end
      end else if (r.aw_addr == msc_pkg::REG_PORT) begin
        next_r.bresp = msc_pkg::RESP_OKAY;
      end else if (r.aw_addr == msc_pkg::REG_SEQ) begin
        next_r.bresp = msc_pkg::RESP_SLVERR;
      end else begin
        next_r.bresp = msc_pkg::RESP_SLVERR;
      end
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      r.st               <= msc_pkg::ST_IDLE;
      r.seq              <= msc_pkg::SEQ_IDLE;
      r.stage            <= 2'h0;
      r.pol              <= 1'b0;
      r.conv50           <= 1'b0;
      r.line_freq_select <= 1'b0;
      r.sel              <= msc_pkg::SEL_RST;
      r.start_pend       <= 1'b0;
      r.result           <= msc_pkg::RES_RST;
      r.coll             <= 1'b0;
      r.rd_lo            <= 1'b0;
      r.rd_hi            <= 1'b0;
      r.aw_held          <= 1'b0;
      r.aw_addr          <= 8'h00;
      r.w_held           <= 1'b0;
      r.w_data           <= 32'h00000000;
      r.w_strb           <= 4'h0;
      r.bvalid           <= 1'b0;
      r.bresp            <= msc_pkg::RESP_OKAY;
      r.rvalid           <= 1'b0;
      r.rdata            <= 32'h00000000;
      r.rresp            <= msc_pkg::RESP_OKAY;
    end else begin
      r <= next_r;
    end
  end

  // ==========================================================
  // Outputs
  assign s_axi_awready        = !r.aw_held;
  assign s_axi_wready         = !r.w_held;
  assign s_axi_bvalid         = r.bvalid;
  assign s_axi_bresp          = r.bresp;
  assign s_axi_arready        = !r.rvalid;
  assign s_axi_rvalid         = r.rvalid;
  assign s_axi_rdata          = r.rdata;
  assign s_axi_rresp          = r.rresp;

  assign zero_integrate_phase = (r.st == msc_pkg::ST_IDLE) || (r.st == msc_pkg::ST_PRE)
                                || (r.st == msc_pkg::ST_POST);
  // R25 integrate flag
  assign integrate_phase      = (r.st == msc_pkg::ST_INT);
  assign int_active           = (r.st == msc_pkg::ST_INT);
  assign deint_phase          = (r.st == msc_pkg::ST_DEINT);
  assign deint_ref_negative   = r.pol;
  assign rest_phase           = (r.st == msc_pkg::ST_REST);
  assign residue_gain_phase   = (r.st == msc_pkg::ST_X8);
  // R22 done at count 0000
  assign eoc                  = (r.st == msc_pkg::ST_IDLE);

endmodule // msc_sequencer

// ---- tb/msc_sequencer_properties.sv ----
`timescale 1ns/100ps
module msc_seq_checker (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        zero_integrate_phase,
  input wire logic        integrate_phase,
  input wire logic        int_active,
  input wire logic        residue_gain_phase,
  input wire logic        rest_phase,
  input wire logic        eoc
);
  // ==========================================================
  // Phase length counters
  logic [11:0] conv_cnt;
  logic [11:0] zi_cnt;
  logic [11:0] int_cnt;
  logic [1:0]  gain_cnt;
  logic        mode60;

  always_ff @(posedge clk) begin
    conv_cnt <= (sys_rst || eoc) ? 12'h000 : conv_cnt + 12'h001;
    zi_cnt   <= (!sys_rst && zero_integrate_phase && !eoc) ? zi_cnt + 12'h001 : 12'h000;
    int_cnt  <= (!sys_rst && integrate_phase) ? int_cnt + 12'h001 : 12'h000;
    if (sys_rst || eoc) begin
      gain_cnt <= 2'h0;
    end else if ($rose(residue_gain_phase)) begin
      gain_cnt <= gain_cnt + 2'h1;
    end
    if ($rose(integrate_phase)) begin
      mode60 <= (zi_cnt == 12'h06f);
    end
  end

  // ==========================================================
  // Properties
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  sequence s_gain_run;
    residue_gain_phase [*8] ##1 !residue_gain_phase;
  endsequence

  a_gain_len: assert property ($rose(residue_gain_phase) |-> s_gain_run)
    else $error("residue gain phase not 8 clocks");
  a_gain_count: assert property ($rose(eoc) |-> gain_cnt == 2'h3)
    else $error("residue gain phase count not 3");
  a_conv_len: assert property ($rose(eoc) |-> conv_cnt == 12'h7ff)
    else $error("conversion length wrong");
  a_post_zero: assert property ($rose(eoc) |-> zi_cnt == 12'h014)
    else $error("closing zero integrate not 20 clocks");
  a_pre_zero: assert property ($rose(integrate_phase) |->
    zi_cnt == 12'h06f || zi_cnt == 12'h001)
    else $error("opening zero integrate length wrong");
  a_int_len: assert property ($fell(integrate_phase) |->
    int_cnt == (mode60 ? 12'h221 : 12'h28f))
    else $error("integrate length wrong");
  a_int_flag: assert property (int_active == integrate_phase)
    else $error("integrate flag differs from phase");
  a_idle_zero: assert property (eoc |-> zero_integrate_phase && !integrate_phase)
    else $error("idle without zero integrate");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_rest_end: assert property ($fell(rest_phase) |->
    residue_gain_phase || zero_integrate_phase)
    else $error("rest ended early");
endmodule // msc_seq_checker

bind msc_sequencer msc_seq_checker u_msc_seq_checker (
  .clk(clk), .sys_rst(sys_rst), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_bresp(s_axi_bresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata), .zero_integrate_phase(zero_integrate_phase),
  .integrate_phase(integrate_phase), .int_active(int_active),
  .residue_gain_phase(residue_gain_phase), .rest_phase(rest_phase), .eoc(eoc));

// ---- tb/msc_integ_model.sv ----
`timescale 1ns/100ps
module msc_integ_model #(
  parameter longint REF_STEP = 1024
) (
  input  wire logic               clk,
  input  wire logic signed [31:0] vin,
  input  wire logic               zero_integrate_phase,
  input  wire logic               integrate_phase,
  input  wire logic               deint_phase,
  input  wire logic               deint_ref_negative,
  input  wire logic               residue_gain_phase,
  output logic                    comp_in
);
  longint v      = 0;
  logic   gain_q = 1'h0;

  // Ramp, hold in rest, invert and gain
  always @(posedge clk) begin
    gain_q <= residue_gain_phase;
    if (zero_integrate_phase) begin
      v <= 0;
    end else if (integrate_phase) begin
      v <= v + vin;
    end else if (deint_phase) begin
      v <= deint_ref_negative ? v - REF_STEP : v + REF_STEP;
    end else if (residue_gain_phase && !gain_q) begin
      v <= -8 * v;
    end
  end

  assign comp_in = v > 0;
endmodule // msc_integ_model

// ---- tb/tb.sv ----
`timescale 1ns/100ps
module tb;
  typedef struct packed {
    logic [1:0]  r;
    logic [31:0] d;
    logic [31:0] m;
  } msc_exp_t;

  logic clk = 1'h0, sys_rst = 1'h1, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic arvalid = 1'h0, rready = 1'h0, awready, wready, bvalid, arready, rvalid, eoc;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [1:0]  bresp, rresp;
  logic signed [31:0] vin = 32'sh0;
  logic comp_in, zip, intp, deint, refneg, gain;
  int fail_count = 0, check_count = 0;
  msc_exp_t rq[$];
  logic [1:0] bq[$];
  msc_exp_t e;

  always #50 clk = ~clk;

  msc_sequencer u_msc_sequencer (
    .clk(clk), .sys_rst(sys_rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .comp_in(comp_in), .zero_integrate_phase(zip), .integrate_phase(intp),
    .deint_phase(deint), .deint_ref_negative(refneg), .rest_phase(),
    .residue_gain_phase(gain), .eoc(eoc), .int_active());

  msc_integ_model u_msc_integ_model (
    .clk(clk), .vin(vin), .zero_integrate_phase(zip), .integrate_phase(intp),
    .deint_phase(deint), .deint_ref_negative(refneg), .residue_gain_phase(gain),
    .comp_in(comp_in));

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // ==========================================================
  // Response monitor
  always @(posedge clk) begin
    if (rvalid === 1'h1 && rready) begin
      e = rq.pop_front();
      check("rdata", rdata & e.m, e.d & e.m);
      check("rresp", {30'h0, rresp}, {30'h0, e.r});
    end
    if (bvalid === 1'h1 && bready) check("bresp", {30'h0, bresp}, {30'h0, bq.pop_front()});
  end

  // ==========================================================
  // Bus tasks
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    bq.push_back(r);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (n = 0; n < 200; n++) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
      if (bvalid) break;
    end
    bready <= 1'h0;
    if (n == 200) fail_count++;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
                    input logic [1:0] r, output logic [31:0] got);
    int n;
    rq.push_back('{r, d, m});
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (n = 0; n < 200; n++) begin
      @(posedge clk);
      if (arready) arvalid <= 1'h0;
      if (rvalid) break;
    end
    got = rdata;
    rready <= 1'h0;
    if (n == 200) fail_count++;
  endtask

  task automatic sel(input logic [1:0] s);
    wr(msc_pkg::REG_CMD, {30'h0, s}, msc_pkg::RESP_OKAY);
  endtask

  task automatic conv(input logic f, input int v);
    int n;
    vin <= v;
    wr(msc_pkg::REG_CMD, {24'h0, 1'h1, f, 6'h0}, msc_pkg::RESP_OKAY);
    for (n = 0; n < 3000 && eoc; n++) @(posedge clk);
    if (n == 3000) fail_count++;
    for (n = 0; n < 3000 && !eoc; n++) @(posedge clk);
    if (n == 3000) fail_count++;
  endtask

  task automatic res(input logic [19:0] x, input logic exact, output logic [19:0] got);
    logic [31:0] lo, hi, st, m;
    m = exact ? 32'hff : 32'h0;
    sel(msc_pkg::SEL_LO);
    rd(msc_pkg::REG_PORT, {24'h0, x[10:3]}, m, msc_pkg::RESP_OKAY, lo);
    sel(msc_pkg::SEL_HI);
    rd(msc_pkg::REG_PORT, {24'h0, x[18:11]}, m, msc_pkg::RESP_OKAY, hi);
    sel(msc_pkg::SEL_STATUS);
    rd(msc_pkg::REG_PORT, {25'h0, x[19], 3'h2, x[2:0]}, m | 32'h38, msc_pkg::RESP_OKAY, st);
    got = {st[6], hi[7:0], lo[7:0], st[2:0]};
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    logic [31:0] g;
    logic [19:0] r;
    int i, v, ex, d;
    void'($urandom(98));
    repeat (5) @(posedge clk);
    sys_rst <= 1'h0;
    rd(msc_pkg::REG_CMD, 32'h0, 32'hffffffff, msc_pkg::RESP_OKAY, g);
    rd(8'h0c, 32'h0, 32'hffffffff, msc_pkg::RESP_SLVERR, g);
    wr(8'h0c, 32'h80, msc_pkg::RESP_SLVERR);
    wr(msc_pkg::REG_SEQ, 32'h80, msc_pkg::RESP_SLVERR);
    repeat (3) @(posedge clk);
    rd(msc_pkg::REG_SEQ, 32'h1000, 32'hffffffff, msc_pkg::RESP_OKAY, g);
    for (i = 0; i < 4; i++) begin
      conv(i[0], i[1] ? -3000 : 3000);
      res(i[1] ? -msc_pkg::HARD_LIMIT : msc_pkg::HARD_LIMIT, 1'h1, r);
    end
    for (i = 0; i < 4; i++) begin
      v = int'($urandom_range(600)) - 300;
      conv(i[0], v);
      ex = v * (i[0] ? 655 : 545) / 2;
      res(20'h0, 1'h0, r);
      d = $signed(r) - ex;
      check("result", {31'h0, d <= 8 && d >= -8}, 32'h1);
    end
    sel(msc_pkg::SEL_LO);
    rd(msc_pkg::REG_PORT, 32'h0, 32'h0, msc_pkg::RESP_OKAY, g);
    conv(1'h1, 100);
    sel(msc_pkg::SEL_STATUS);
    // Flag set then cleared by status read
    rd(msc_pkg::REG_PORT, 32'h20, 32'h20, msc_pkg::RESP_OKAY, g);
    rd(msc_pkg::REG_PORT, 32'h0, 32'h20, msc_pkg::RESP_OKAY, g);
    repeat (30) @(posedge clk);
    check("eoc", {31'h0, eoc}, 32'h1);
    test_done;
  end

  initial begin
    #4000000;
    fail_count++;
    test_done;
  end
endmodule // tb
